// [bench/fskm_modem_tb.sv]
// self-checking bench for the fsk tape modem against a tape model
module fskm_modem_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fskm_pkg::*;
    logic        clk, rstn, av_rd, av_wr, av_wait;
    logic [3:0]  av_a;
    logic [31:0] av_wd, av_q;
    logic        ft, txt, rxt, tx_ser, sy_ser, pin, fout;
    logic        rser, rdone, sser, sdone;
    logic        play, dat, fast, inv, alt, idle_hi;
    logic [2:0]  tcnt = 3'h0;
    int          cycles = 0;
    int          mismatches = 0;
    int          n_compared = 0;

    fskm_modem DUT (.i_sys_clk(clk), .i_rstn(rstn), .i_avs_address(av_a),
        .i_avs_read(av_rd), .i_avs_write(av_wr), .i_avs_writedata(av_wd),
        .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait),
        .i_fine_tick16(ft), .i_tx_tick16(txt), .i_rx_tick16(rxt),
        .i_tx_serial(tx_ser), .i_sync_serial(sy_ser), .i_fsk_in_pin(pin),
        .o_fsk_out_pin(fout), .o_rx_serial(rser), .o_rx_bit_done(rdone),
        .o_sync_serial(sser), .o_sync_bit_done(sdone));

    fskm_tape_model tape (.i_sys_clk(clk), .i_rstn(rstn), .i_tick(rxt),
        .i_play(play), .i_data(dat), .i_fast(fast), .i_invert(inv),
        .i_alt(alt), .i_idle_hi(idle_hi), .o_pin(pin));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // rate ticks: fine every 2, rx every 4, tx every 8 clocks; slow rates
    // only, never the fast midi divisors
    always @(posedge clk)
    begin
        tcnt <= tcnt + 3'h1;
        ft   <= tcnt[0];
        rxt  <= (tcnt[1:0] == 2'h3);
        txt  <= (tcnt == 3'h7);
    end
    // hang guard well above the expected run length
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            mismatches++;
            report_and_stop();
        end
    end

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("ERROR %0t: got %h expected %h", $time, seen, exp);
        end
    endtask

    // one avalon transfer: held until waitrequest is seen low at a rising
    // edge, where read data is taken; released only after that edge
    task automatic bus(input logic [3:0] a, input logic wr,
                       input logic [7:0] wd, output logic [7:0] q);
        int n;
        n = 0;
        av_a  <= a;
        av_wr <= wr;
        av_rd <= ~wr;
        av_wd <= {24'h0, wd};
        @(posedge clk);
        while (av_wait !== 1'b0 && n < 64)
        begin
            @(posedge clk);
            n++;
        end
        if (n >= 64)
            check(8'h01, 8'h00);
        q = av_q[7:0];
        av_rd <= 1'b0;
        av_wr <= 1'b0;
        @(posedge clk);
    endtask

    // counts out pin rises (0), rx strobes (1) or sync strobes (2)
    task automatic count(input int ncyc, input int sel,
                         output logic [7:0] n);
        logic prev;
        n = 8'h00;
        prev = fout;
        repeat (ncyc)
        begin
            @(negedge clk);
            if ((sel == 0 && fout === 1'b1 && prev === 1'b0) ||
                (sel == 1 && rdone === 1'b1) || (sel == 2 && sdone === 1'b1))
                n++;
            prev = fout;
        end
        @(posedge clk);
    endtask

    task automatic set_tape(input logic p, d, f, i, al, int wait_cyc);
        play <= p;
        dat  <= d;
        fast <= f;
        inv  <= i;
        alt  <= al;
        repeat (wait_cyc) @(posedge clk);
    endtask

    task automatic t_regs();
        logic [7:0] q;
        idle_hi <= 1'b1;
        repeat (8) @(posedge clk);
        bus(4'h3, 1'b0, 8'h00, q);
        check(q, 8'h00);
        bus(FSKM_ADDR_CONTROL, 1'b0, 8'h00, q);
        check(q, 8'h00);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_PIN]}, 8'h01);
        idle_hi <= 1'b0;
        repeat (8) @(posedge clk);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_PIN]}, 8'h00);
        $display("test regs done");
    endtask

    // mark gives 8 rises in 64 ticks, space 4; halted gives none
    task automatic t_mod();
        logic [7:0] q, n;
        bus(FSKM_ADDR_RATE, 1'b1, 8'h01, q);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h80, q);
        tx_ser <= 1'b1;
        repeat (256) @(posedge clk);
        count(512, 0, n);
        check(n, 8'h08);
        tx_ser <= 1'b0;
        repeat (256) @(posedge clk);
        count(512, 0, n);
        check(n, 8'h04);
        bus(FSKM_ADDR_RATE, 1'b1, 8'h00, q);
        sy_ser <= 1'b1;
        repeat (256) @(posedge clk);
        count(256, 0, n);
        check(n, 8'h08);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h00, q);
        repeat (64) @(posedge clk);
        count(256, 0, n);
        check(n, 8'h00);
        $display("test modulator done");
    endtask

    // steady marks then spaces at 64 clocks a bit: 16 strobes a window
    task automatic t_demod();
        logic [7:0] q, n;
        bus(FSKM_ADDR_RATE, 1'b1, 8'h02, q);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h0c, q);
        for (int b = 1; b >= 0; b--)
        begin
            set_tape(1'b1, b[0], 1'b0, 1'b0, 1'b0, 256);
            count(1024, 1, n);
            check(n, 8'h10);
            check({7'h0, rser}, {7'h0, b[0]});
            bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
            check({7'h0, q[ST_LEVEL]}, {7'h0, b[0]});
        end
        bus(FSKM_ADDR_RATE, 1'b1, 8'h00, q);
        repeat (128) @(posedge clk);
        count(1024, 2, n);
        check(n, 8'h10);
        check({7'h0, sser}, 8'h00);
        count(256, 1, n);
        check(n, 8'h00);
        bus(FSKM_ADDR_RATE, 1'b1, 8'h02, q);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h04, q);
        count(512, 1, n);
        check(n, 8'h00);
        $display("test demodulator done");
    endtask

    task automatic t_rate();
        logic [7:0] q, n;
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h0c, q);
        set_tape(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 512);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_FAST]}, 8'h01);
        set_tape(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 512);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_SLOW]}, 8'h01);
        check({7'h0, q[ST_LEVEL]}, 8'h00);
        check({7'h0, rser}, 8'h01);
        // temporary bits repeat every 21 ticks, 84 clocks
        count(840, 1, n);
        check(n, 8'h0a);
        set_tape(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 256);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h1c, q);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({6'h0, q[ST_SLOW], q[ST_FAST]}, 8'h00);
        $display("test carrier rate done");
    endtask

    // alternating marks and spaces let the detector find the edge
    task automatic t_pol();
        logic [7:0] q;
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h09, q);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_PFOUND]}, 8'h00);
        set_tape(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1024);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_PFOUND]}, 8'h01);
        check({7'h0, q[ST_POL]}, 8'h00);
        set_tape(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1024);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_POL]}, 8'h01);
        set_tape(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 64);
        bus(FSKM_ADDR_CONTROL, 1'b1, 8'h09, q);
        bus(FSKM_ADDR_STATUS, 1'b0, 8'h00, q);
        check({7'h0, q[ST_PFOUND]}, 8'h00);
        $display("test polarity done");
    endtask

    initial
    begin
        rstn = 1'b0;
        {av_rd, av_wr, av_a, av_wd} = '0;
        {tx_ser, sy_ser, play, dat, fast, inv, alt, idle_hi} = '0;
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_regs();
        t_mod();
        t_demod();
        t_rate();
        t_pol();
        report_and_stop();
    end
endmodule

// [bench/fskm_tape_model.sv]
// tape recorder playback model driving fsk square waves into the modem
module fskm_tape_model
(
    input  wire logic i_sys_clk,
    input  wire logic i_rstn,
    input  wire logic i_tick,
    input  wire logic i_play,
    input  wire logic i_data,
    input  wire logic i_fast,
    input  wire logic i_invert,
    input  wire logic i_alt,
    input  wire logic i_idle_hi,
    output logic      o_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] phase;
    logic [4:0] nxt;
    logic       bsel;
    logic       dat;
    // a fast tape steps the phase twice per tick, so bits are half length
    assign nxt = {1'b0, phase} + (i_fast ? 5'h02 : 5'h01);
    // phase of the current bit; alternating data flips at every bit end
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase <= 4'h0;
            bsel  <= 1'b0;
        end
        else if (i_tick && i_play)
        begin
            phase <= nxt[3:0];
            if (nxt[4])
                bsel <= ~bsel;
        end
    end
    // mark is two periods a bit, space one; silence holds a fixed level
    assign dat   = i_alt ? bsel : i_data;
    assign o_pin = i_play ? ((dat ? ~phase[2] : ~phase[3]) ^ i_invert)
                          : i_idle_hi;
endmodule

// [hdl/fskm_modem.sv]
// fsk tape modem: modulator, demodulator, polarity follow-up, avalon slave
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
module fskm_modem
    import fskm_pkg::*;
(
    input  wire logic       i_sys_clk,
    input  wire logic       i_rstn,
    input  wire logic [3:0] i_avs_address,
    input  wire logic       i_avs_read,
    input  wire logic       i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic [31:0]     o_avs_readdata,
    output logic            o_avs_waitrequest,
    input  wire logic       i_fine_tick16,
    input  wire logic       i_tx_tick16,
    input  wire logic       i_rx_tick16,
    input  wire logic       i_tx_serial,
    input  wire logic       i_sync_serial,
    input  wire logic       i_fsk_in_pin,
    output logic            o_fsk_out_pin,
    output logic            o_rx_serial,
    output logic            o_rx_bit_done,
    output logic            o_sync_serial,
    output logic            o_sync_bit_done
);
    import fskm_pkg::*;

    // tap positions and the phase counts assume this sampling layout
    if (OVERSAMPLE != 16 || POL_TAPS != 12)
        $error("fskm_modem: unsupported sampling layout");

    logic [7:0] control;
    logic [7:0] rate_sel;
    logic [2:0] pin_sync;
    logic       pin_level;
    logic [4:0] sync_div;
    logic       sync_tick16;
    logic       tx_tick16;
    logic       rx_tick16;
    logic [3:0] tx_phase;
    logic       tx_bit;
    logic [4:0] phase;
    logic       seen_rise;
    logic       temp_bit;
    logic       prev_in;
    logic       demod_level_flag;
    logic       carrier_slow_flag;
    logic       carrier_fast_flag;
    logic       polarity_result;
    logic       polarity_found_flag;
    logic [11:0] pol_shift;
    logic       pol_detect;
    logic       pol_value;
    logic       polar_in;
    logic       rise;
    logic       wr_ctl;
    logic       rd_pend;
    logic       bit_done;
    logic       bit_value;

    // three-stage synchroniser; a change counts when stages two and three agree
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pin_sync <= 3'h0;
        else
            pin_sync <= {pin_sync[1:0], i_fsk_in_pin};
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            pin_level <= 1'b0;
        else if (pin_sync[1] == pin_sync[2])
            pin_level <= pin_sync[2];
    end

    // fixed 1200 bps sampling tick: fine clock 16x ticks divided by 2, so /32 per bit
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            sync_div    <= 5'h00;
            sync_tick16 <= 1'b0;
        end
        else
        begin
            sync_tick16 <= 1'b0;
            if (i_fine_tick16)
            begin
                if (sync_div == 5'(SYNC_TICK_DIV / OVERSAMPLE - 1))
                begin
                    sync_div    <= 5'h00;
                    sync_tick16 <= 1'b1;
                end
                else
                    sync_div <= sync_div + 5'h01;
            end
        end
    end

    // path selection of sampling rates
    assign tx_tick16 = rate_sel[RT_TX_PATH] ? i_tx_tick16 : sync_tick16;
    assign rx_tick16 = rate_sel[RT_RX_PATH] ? i_rx_tick16 : sync_tick16;

    // modulator: phase 0..15 per bit; mark toggles every 4, space every 8
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            tx_phase      <= 4'h0;
            tx_bit        <= 1'b0;
            o_fsk_out_pin <= 1'b0;
        end
        else if (!control[CT_TX_RUN])
        begin
            tx_phase      <= 4'h0;
            o_fsk_out_pin <= 1'b0;
        end
        else if (tx_tick16)
        begin
            tx_phase <= tx_phase + 4'h1;
            if (tx_phase == 4'h0)
            begin
                tx_bit        <= rate_sel[RT_TX_PATH] ? i_tx_serial
                                                      : i_sync_serial;
                o_fsk_out_pin <= 1'b1;
            end
            else if (tx_bit ? (tx_phase[1:0] == 2'h0)
                            : (tx_phase[2:0] == 3'h0))
                o_fsk_out_pin <= ~o_fsk_out_pin;
        end
    end

    // polarity: manual bit or detected result drives inversion
    assign polar_in = control[CT_APOL_OFF] ? (pin_level ^ control[CT_MAN_POL])
                                           : (pin_level ^ polarity_result);
    // only taps 7 and 8 differ from 1,5,6,12: a mark-to-space transition
    assign pol_detect = (pol_shift[11] == pol_shift[5])
                        && (pol_shift[5] == pol_shift[4])
                        && (pol_shift[4] == pol_shift[0])
                        && (pol_shift[7] != pol_shift[11])
                        && (pol_shift[6] != pol_shift[11]);
    // positive when the space starts on a falling edge (tap 7 high)
    assign pol_value = ~pol_shift[5];
    assign rise = rx_tick16 && polar_in && !prev_in;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            pol_shift       <= 12'h000;
            polarity_result <= 1'b0;
        end
        else if (rx_tick16 && control[CT_RX_RUN])
        begin
            pol_shift <= {pol_shift[10:0], pin_level};
            if (pol_detect && !control[CT_APOL_OFF])
                polarity_result <= pol_value;
        end
    end

    // demodulator phase counter and decision
    assign bit_done = rx_tick16 && control[CT_RX_RUN] && phase == PH_DECIDE;
    assign bit_value = seen_rise && !temp_bit;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            phase      <= 5'h00;
            seen_rise  <= 1'b0;
            temp_bit   <= 1'b0;
            prev_in    <= 1'b0;
        end
        else if (!control[CT_RX_RUN])
        begin
            phase     <= 5'h00;
            seen_rise <= 1'b0;
            temp_bit  <= 1'b0;
        end
        else if (rx_tick16)
        begin
            prev_in <= polar_in;
            if (pol_detect && !control[CT_APOL_OFF])
            begin
                phase     <= PH_LOAD;
                seen_rise <= 1'b0;
                temp_bit  <= 1'b0;
            end
            else if (phase == 5'h00)
            begin
                if (rise)
                    phase <= PH_LOAD;
            end
            else if (rise && phase < PH_DECIDE && !temp_bit)
            begin
                seen_rise <= 1'b1;
                phase     <= phase + 5'h01;
            end
            else if (rise)
            begin
                // next bit starts; an edge also ends a run of temporary bits
                phase     <= PH_LOAD;
                seen_rise <= 1'b0;
                temp_bit  <= 1'b0;
            end
            else if (phase == PH_SLOW)
            begin
                phase     <= PH_LOAD;
                seen_rise <= 1'b0;
                temp_bit  <= 1'b1;
            end
            else
                phase <= phase + 5'h01;
        end
    end

    // outputs toward receiver and sync detector; temporary bit reads high
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_rx_serial      <= 1'b1;
            o_rx_bit_done    <= 1'b0;
            o_sync_serial    <= 1'b1;
            o_sync_bit_done  <= 1'b0;
            demod_level_flag <= 1'b0;
        end
        else
        begin
            o_rx_bit_done   <= bit_done && rate_sel[RT_RX_PATH];
            o_sync_bit_done <= bit_done && !rate_sel[RT_RX_PATH];
            if (bit_done)
            begin
                demod_level_flag <= bit_value;
                if (rate_sel[RT_RX_PATH])
                    o_rx_serial <= bit_value || temp_bit;
                else
                    o_sync_serial <= bit_value || temp_bit;
            end
        end
    end

    // sticky flags; a set in the same cycle as a clear wins
    // a write lands only at the edge where waitrequest is low
    assign wr_ctl = i_avs_write && !o_avs_waitrequest
                    && i_avs_address == FSKM_ADDR_CONTROL;

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            carrier_slow_flag   <= 1'b0;
            carrier_fast_flag   <= 1'b0;
            polarity_found_flag <= 1'b0;
        end
        else
        begin
            if (rx_tick16 && control[CT_RX_RUN] && phase == PH_SLOW
                && !rise)
                carrier_slow_flag <= 1'b1;
            else if (wr_ctl && i_avs_writedata[CT_CLR_RATE])
                carrier_slow_flag <= 1'b0;
            if (rx_tick16 && control[CT_RX_RUN] && rise && seen_rise
                && phase < PH_DECIDE)
                carrier_fast_flag <= 1'b1;
            else if (wr_ctl && i_avs_writedata[CT_CLR_RATE])
                carrier_fast_flag <= 1'b0;
            if (rx_tick16 && control[CT_RX_RUN] && pol_detect)
                polarity_found_flag <= 1'b1;
            else if (wr_ctl && i_avs_writedata[CT_CLR_POL])
                polarity_found_flag <= 1'b0;
        end
    end

    // register writes; clear bits are pulses and are not stored
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            control  <= FSKM_CONTROL_RESET;
            rate_sel <= FSKM_RATE_RESET;
        end
        else if (i_avs_write && !o_avs_waitrequest)
        begin
            if (i_avs_address == FSKM_ADDR_CONTROL)
                control <= i_avs_writedata[7:0]
                    & ~(8'h01 << CT_CLR_RATE) & ~(8'h01 << CT_CLR_POL);
            else if (i_avs_address == FSKM_ADDR_RATE)
                rate_sel <= i_avs_writedata[7:0] & 8'h03;
        end
    end

    // every transfer waits one cycle so readdata comes from a flip-flop
    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            rd_pend        <= 1'b0;
            o_avs_readdata <= 32'h0000_0000;
        end
        else
        begin
            rd_pend <= (i_avs_read || i_avs_write) && !rd_pend;
            if (i_avs_read && !rd_pend)
            begin
                unique case (i_avs_address)
                    FSKM_ADDR_STATUS:
                        o_avs_readdata <= {24'h000000, pin_level,
                            demod_level_flag, carrier_slow_flag,
                            carrier_fast_flag, 2'h0, polarity_result,
                            polarity_found_flag};
                    FSKM_ADDR_RATE:
                        o_avs_readdata <= {24'h000000, rate_sel};
                    default:
                        o_avs_readdata <= 32'h0000_0000; // write-only or unmapped
                endcase
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rstn)
    begin
        if (!i_rstn)
            o_avs_waitrequest <= 1'b1;
        else
            o_avs_waitrequest <= !((i_avs_read || i_avs_write) && !rd_pend);
    end

    // checks
    slow_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (rx_tick16 && control[CT_RX_RUN] && phase == PH_SLOW && !rise)
        |=> carrier_slow_flag) else $error("slow flag not set");
    pol_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        (rx_tick16 && control[CT_RX_RUN] && pol_detect)
        |=> polarity_found_flag) else $error("found flag missed");
    strobe_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        bit_done && rate_sel[RT_RX_PATH] |=> o_rx_bit_done)
        else $error("bit strobe missing");
    temp_high_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        bit_done && temp_bit && rate_sel[RT_RX_PATH]
        |=> o_rx_serial && !demod_level_flag)
        else $error("temporary bit level wrong");
    tx_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !control[CT_TX_RUN] |=> !o_fsk_out_pin)
        else $error("modulator not halted");
    rx_halt_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        !control[CT_RX_RUN] |=> phase == 5'h00)
        else $error("demodulator not halted");
    clr_rate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        wr_ctl && i_avs_writedata[CT_CLR_RATE] && !rx_tick16
        |=> !carrier_slow_flag && !carrier_fast_flag)
        else $error("rate flags not cleared");
    phase_max_a: assert property (@(posedge i_sys_clk) disable iff (!i_rstn)
        phase <= PH_SLOW) else $error("phase beyond slow limit");
    cover_bit_c: cover property (@(posedge i_sys_clk) o_rx_bit_done);
    cover_slow_c: cover property (@(posedge i_sys_clk) carrier_slow_flag);
    cover_pol_c: cover property (@(posedge i_sys_clk) polarity_found_flag);
endmodule

// [hdl/fskm_pkg.sv]
// package: register map, field positions and timing constants of the fsk tape modem
package fskm_pkg;
    // register word addresses (byte address = 4 * index)
    localparam logic [3:0] FSKM_ADDR_STATUS  = 4'h0;
    localparam logic [3:0] FSKM_ADDR_CONTROL = 4'h1;
    localparam logic [3:0] FSKM_ADDR_RATE    = 4'h2;
    // status bit positions
    localparam int ST_PIN   = 7;
    localparam int ST_LEVEL = 6;
    localparam int ST_SLOW  = 5;
    localparam int ST_FAST  = 4;
    localparam int ST_POL   = 1;
    localparam int ST_PFOUND = 0;
    // control bit positions
    localparam int CT_TX_RUN   = 7;
    localparam int CT_CLR_RATE = 4;
    localparam int CT_RX_RUN   = 3;
    localparam int CT_APOL_OFF = 2;
    localparam int CT_MAN_POL  = 1;
    localparam int CT_CLR_POL  = 0;
    // rate register: bit 0 transmit path select, bit 1 receive path select
    localparam int RT_TX_PATH = 0;
    localparam int RT_RX_PATH = 1;
    localparam logic [7:0] FSKM_CONTROL_RESET = 8'h00;
    localparam logic [7:0] FSKM_RATE_RESET    = 8'h00;
    // demodulator phase counts
    localparam logic [4:0] PH_LOAD   = 5'h01;
    localparam logic [4:0] PH_DECIDE = 5'h0d;
    localparam logic [4:0] PH_SLOW   = 5'h15;
    // oversampling ratio and fixed sync rate divider (fine clock / 512 per bit)
    localparam int OVERSAMPLE     = 16;
    localparam int SYNC_BIT_DIV   = 512;
    localparam int SYNC_TICK_DIV  = SYNC_BIT_DIV / OVERSAMPLE;
    localparam int POL_TAPS       = 12;
endpackage
